// File: verilog/cmf_pkg.sv
// constants, field layouts and layout helpers for the message store
// assumes one system clock; shared by the store and its ecc codec
package cmf_pkg;
	// message ram geometry
	localparam int RAM_BYTES = 2048;
	localparam int RAM_WORDS = RAM_BYTES / 4;
	localparam int RAM_AW    = 9;
	localparam int DW        = 32;
	localparam int PW        = 7;
	localparam int HW        = 6;
	localparam int CW        = 39;
	localparam int AW        = 12;
	localparam int WORD_SHIFT = 2;

	// host map: ram window and filter/mask pairs
	localparam logic [11:0] RAM_BASE = 12'h400;
	localparam logic [11:0] RAM_LAST = 12'hbff;
	localparam logic [11:0] FLT_BASE = 12'h1f0;
	localparam logic [11:0] FLT_LAST = 12'h2ef;
	localparam int FLT_SHIFT    = 3;
	localparam int MASK_SEL_BIT = 2;
	localparam logic [31:0] FLT_RESET = 32'h00000000;
	localparam logic [31:0] FLT_WMASK = 32'h7fffffff;

	// filters and fifos; fifo slot 0 is the transmit queue
	localparam int NFLT  = 32;
	localparam int NFIFO = 32;
	localparam int IXW   = 5;
	localparam int PLW   = 3;
	localparam logic [4:0] FIFO_RSVD = 5'h00;

	// object word fields
	localparam int ID_W        = 30;
	localparam int ID_TYPE_BIT = 30;
	localparam int SEQ_W       = 23;
	localparam int FLAG_W      = 8;
	localparam int HDR_WORDS   = 2;

	// data bytes per object, as words
	function automatic logic [4:0] payload_words(input logic [2:0] c);
		case (c)
			3'h0: return 5'h02;
			3'h1: return 5'h03;
			3'h2: return 5'h04;
			3'h3: return 5'h05;
			3'h4: return 5'h06;
			3'h5: return 5'h08;
			3'h6: return 5'h0c;
			3'h7: return 5'h10;
		endcase
	endfunction

	// words per object: header, optional stamp, payload
	function automatic logic [4:0] obj_words(input logic [2:0] pl,
		input logic ts, input logic has_pl);
		logic [4:0] p;
		p = has_pl ? payload_words(pl) : 5'h00;
		return 5'(HDR_WORDS) + {4'h0, ts} + p;
	endfunction

	// identifier word as placed in word 0 of every object
	function automatic logic [31:0] id_word(input logic s11,
		input logic [17:0] e, input logic [10:0] s);
		return {2'h0, s11, e, s};
	endfunction
endpackage

// File: verilog/cmf_ecc.sv
// sec/ded codec for one message ram word: 32 data bits, 7 check bits
// purely combinational; the caller registers around it
`timescale 1ns/1ps
module cmf_ecc
(
	input  wire logic        enable_in,  // ecc on
	input  wire logic [6:0]  parity_in,  // check bits used while off
	input  wire logic [31:0] wdata_in,   // word being written
	output logic      [38:0] wcode_out,  // {check, data} to store
	input  wire logic [38:0] rcode_in,   // stored {check, data}
	output logic      [31:0] rdata_out,  // corrected data
	output logic             single_out, // one bit corrected
	output logic             double_out  // two bits in error
);
	// place data in the non power-of-two slots of positions 1..38
	function automatic logic [38:0] spread(input logic [31:0] d);
		logic [38:0] c;
		int          k;
		c = '0;
		k = 0;
		for (int i = 1; i < cmf_pkg::CW; i++)
			if ((i & (i - 1)) != 0)
			begin
				c[i] = d[k];
				k++;
			end
		return c;
	endfunction

	function automatic logic [31:0] gather(input logic [38:0] c);
		logic [31:0] d;
		int          k;
		d = '0;
		k = 0;
		for (int i = 1; i < cmf_pkg::CW; i++)
			if ((i & (i - 1)) != 0)
			begin
				d[k] = c[i];
				k++;
			end
		return d;
	endfunction

	function automatic logic [5:0] syndrome(input logic [38:0] c);
		logic [5:0] s;
		s = '0;
		for (int i = 1; i < cmf_pkg::CW; i++)
			if (c[i])
				s = s ^ 6'(i);
		return s;
	endfunction

	logic [5:0]  w_ham;
	logic [38:0] r_cw;
	logic [5:0]  r_syn;
	logic        r_ov;

	always_comb
	begin
		w_ham = syndrome(spread(wdata_in));
		if (enable_in)
			wcode_out = {^{wdata_in, w_ham}, w_ham, wdata_in};
		else
			wcode_out = {parity_in, wdata_in};
	end

	always_comb
	begin
		r_cw = spread(rcode_in[31:0]);
		for (int p = 0; p < cmf_pkg::HW; p++)
			r_cw[1 << p] = rcode_in[cmf_pkg::DW + p];
		r_cw[0] = rcode_in[cmf_pkg::CW - 1];
		r_syn = syndrome(r_cw);
		r_ov = ^r_cw;
		single_out = 1'b0;
		double_out = 1'b0;
		if (enable_in && r_ov)
		begin
			single_out = 1'b1;
			r_cw[r_syn] = ~r_cw[r_syn];
		end
		else if (enable_in && r_syn != 6'h00)
			double_out = 1'b1;
		rdata_out = enable_in ? gather(r_cw) : rcode_in[31:0];
	end
endmodule

// File: verilog/cmf_msg_store.sv
// message ram, object layout, ecc and acceptance filters of a can fd
// controller; the serial decoder and the protocol engine sit outside
// and reach the ram through the host and engine word ports
//
// Behaviour
// - 2 KB message ram holds event, queue and fifo objects, sizes set.
// - payload size set per transmit queue and per fifo.
// - fifo and object configuration is taken only in configuration mode.
// - event objects placed first, space only when event store is on.
// - transmit queue objects follow, space only when the queue is enabled.
// - fifo 1 to 31 objects follow in ascending order.
// - device computes addresses and gives each fifo a user address.
// - each ram word stores 32 data bits and 7 check bits.
// - with ecc on, writes are encoded and reads decoded.
// - with ecc off, stored check bits come from parity field; reads raw.
// - read decoder corrects single errors, flags double errors.
// - word 0 holds sid11 at 29, extended id 28-11, standard id 10-0.
// - transmit word 1 carries 23-bit sequence tag in bits 31-9.
// - in gateway mode sent esi is object esi or error passive.
// - word 1 holds fdf, brs, rtr, ide and dlc in bits 7-0.
// - receive word 1 bits 15-11 hold the matching filter index.
// - receive timestamp word present only when the fifo enables it.
// - event object records id, sequence tag, esi and format flags.
// - event timestamp word present only when event stamping is on.
// - unused bits of id and receive words read zero.
// - filter pointing at fifo 0 never accepts.
`timescale 1ns/1ps
module cmf_msg_store
(
	input  wire logic         clk_in,            // system clock
	input  wire logic         sys_rst_in,        // sync reset
	input  wire logic         config_mode_in,    // configuration mode
	input  wire logic         store_transmit_events_in, // event store
	input  wire logic         transmit_queue_enable_in, // queue on
	input  wire logic         event_timestamp_enable_in, // event stamp
	input  wire logic         ecc_enable_in,     // ecc on
	input  wire logic [6:0]   ecc_parity_in,     // parity while off
	input  wire logic         esi_gateway_mode_in, // gateway esi
	input  wire logic         err_passive_in,    // node error passive
	input  wire logic [4:0]   tef_depth_in,      // event objects - 1
	input  wire logic [4:0]   txq_depth_in,      // queue objects - 1
	input  wire logic [2:0]   txq_payload_size_in, // queue payload
	input  wire logic [159:0] fifo_depth_in,     // 5 bits per fifo
	input  wire logic [95:0]  fifo_payload_size_in, // 3 bits per fifo
	input  wire logic [31:0]  receive_timestamp_enable_in, // per fifo
	input  wire logic [31:0]  fifo_is_tx_in,     // fifo transmits
	input  wire logic [31:0]  fifo_advance_in,   // object consumed
	input  wire logic [4:0]   ua_sel_in,         // fifo to report
	output logic      [11:0]  fifo_user_address_out, // next object
	input  wire logic         host_req_in,       // host word access
	input  wire logic         host_we_in,        // host write
	input  wire logic [11:0]  host_addr_in,      // byte address
	input  wire logic [31:0]  host_wdata_in,     // write data
	output logic              host_ready_out,    // host taken
	output logic              host_rvalid_out,   // host read data
	output logic      [31:0]  host_rdata_out,    // read data
	input  wire logic         eng_req_in,        // engine ram access
	input  wire logic         eng_we_in,         // engine write
	input  wire logic [11:0]  eng_addr_in,       // byte address
	input  wire logic [31:0]  eng_wdata_in,      // write data
	output logic              eng_rvalid_out,    // engine read data
	output logic      [31:0]  eng_rdata_out,     // read data
	output logic              ecc_single_out,    // corrected, pulse
	output logic              ecc_double_out,    // uncorrectable
	input  wire logic [31:0]  filter_enable_in,  // per filter
	input  wire logic [159:0] filter_fifo_ptr_in, // 5 bits per filter
	input  wire logic         rx_check_in,       // id valid, pulse
	input  wire logic         rx_sid11_in,       // id bit 11
	input  wire logic [17:0]  rx_eid_in,         // extended id
	input  wire logic [10:0]  rx_sid_in,         // standard id
	input  wire logic [8:0]   rx_flags_in,       // esi,fdf,brs,rtr,ide,dlc
	output logic              match_valid_out,   // a filter hit
	output logic      [4:0]   matched_filter_index_out, // hit index
	output logic      [4:0]   match_fifo_out,    // target fifo
	output logic      [31:0]  rx_word0_out,      // receive word 0
	output logic      [31:0]  rx_word1_out,      // receive word 1
	input  wire logic [31:0]  tx_word0_in,       // object word 0
	input  wire logic [31:0]  tx_word1_in,       // object word 1
	output logic              tx_esi_out,        // esi to send
	output logic      [31:0]  tef_word0_out,     // event word 0
	output logic      [31:0]  tef_word1_out      // event word 1
);
	// configuration copies
	logic        cfg_store_transmit_events_q, cfg_txq_q, cfg_tefts_q;
	logic [4:0]  cfg_tefd_q, cfg_txqd_q;
	logic [2:0]  cfg_txqpl_q;
	logic [4:0]  cfg_depth_q [cmf_pkg::NFIFO];
	logic [2:0]  cfg_pl_q    [cmf_pkg::NFIFO];
	logic [31:0] cfg_rxts_q, cfg_tx_q;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			cfg_store_transmit_events_q <= 1'b0;
			cfg_txq_q <= 1'b0;
			cfg_tefts_q <= 1'b0;
			cfg_tefd_q <= '0;
			cfg_txqd_q <= '0;
			cfg_txqpl_q <= '0;
			cfg_rxts_q <= '0;
			cfg_tx_q <= '0;
			for (int i = 0; i < cmf_pkg::NFIFO; i++)
			begin
				cfg_depth_q[i] <= '0;
				cfg_pl_q[i] <= '0;
			end
		end
		else if (config_mode_in)
		begin
			cfg_store_transmit_events_q <= store_transmit_events_in;
			cfg_txq_q <= transmit_queue_enable_in;
			cfg_tefts_q <= event_timestamp_enable_in;
			cfg_tefd_q <= tef_depth_in;
			cfg_txqd_q <= txq_depth_in;
			cfg_txqpl_q <= txq_payload_size_in;
			cfg_rxts_q <= receive_timestamp_enable_in;
			cfg_tx_q <= fifo_is_tx_in;
			for (int i = 0; i < cmf_pkg::NFIFO; i++)
			begin
				cfg_depth_q[i] <= fifo_depth_in[i*5 +: 5];
				cfg_pl_q[i] <= fifo_payload_size_in[i*3 +: 3];
			end
		end
	end

	// ram layout in words; slot 0 is the queue, 1..31 the fifos
	logic [11:0] base_w [cmf_pkg::NFIFO];
	logic [4:0]  objw   [cmf_pkg::NFIFO];
	logic [11:0] lay_acc;
	logic        lay_ts;
	always_comb
	begin
		lay_acc = '0;
		lay_ts = 1'b0;
		if (cfg_store_transmit_events_q)
			lay_acc = 12'(cmf_pkg::obj_words(3'h0, cfg_tefts_q, 1'b0)
				* ({1'b0, cfg_tefd_q} + 6'h01));
		objw[0] = cmf_pkg::obj_words(cfg_txqpl_q, 1'b0, 1'b1);
		base_w[0] = lay_acc;
		if (cfg_txq_q)
			lay_acc = lay_acc + 12'(objw[0] * ({1'b0, cfg_txqd_q} + 6'h01));
		for (int i = 1; i < cmf_pkg::NFIFO; i++)
		begin
			lay_ts = cfg_rxts_q[i] & ~cfg_tx_q[i];
			objw[i] = cmf_pkg::obj_words(cfg_pl_q[i], lay_ts, 1'b1);
			base_w[i] = lay_acc;
			lay_acc = lay_acc + 12'(objw[i]
				* ({1'b0, cfg_depth_q[i]} + 6'h01));
		end
	end

	// object index per fifo, cleared in configuration mode
	logic [4:0] obj_idx_q [cmf_pkg::NFIFO];
	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < cmf_pkg::NFIFO; i++)
			if (sys_rst_in || config_mode_in)
				obj_idx_q[i] <= '0;
			else if (fifo_advance_in[i])
				// slot 0 wraps at the queue depth, not at a fifo depth
				obj_idx_q[i] <= (obj_idx_q[i]
					== (i == 0 ? cfg_txqd_q : cfg_depth_q[i]))
					? 5'h00 : obj_idx_q[i] + 5'h01;
	end

	logic [11:0] ua_w;
	assign ua_w = base_w[ua_sel_in]
		+ 12'(objw[ua_sel_in] * obj_idx_q[ua_sel_in]);
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			fifo_user_address_out <= cmf_pkg::RAM_BASE;
		else
			fifo_user_address_out <= cmf_pkg::RAM_BASE
				+ {ua_w[9:0], 2'h0};
	end

	// access arbitration: the engine always wins the ram
	logic        eng_go, host_go, acc_go, acc_we, acc_ram;
	logic [11:0] acc_addr, ram_off, flt_off;
	logic [31:0] acc_wdata;
	logic [8:0]  ram_idx;
	logic        flt_sel, flt_mask;
	logic [4:0]  flt_m;
	assign eng_go = eng_req_in;
	assign host_go = host_req_in & ~eng_req_in;
	assign host_ready_out = ~eng_req_in;
	assign acc_go = eng_go | host_go;
	assign acc_we = eng_go ? eng_we_in : host_we_in;
	assign acc_addr = eng_go ? eng_addr_in : host_addr_in;
	assign acc_wdata = eng_go ? eng_wdata_in : host_wdata_in;
	assign acc_ram = acc_addr >= cmf_pkg::RAM_BASE
		&& acc_addr <= cmf_pkg::RAM_LAST;
	assign ram_off = acc_addr - cmf_pkg::RAM_BASE;
	assign ram_idx = ram_off[cmf_pkg::RAM_AW+cmf_pkg::WORD_SHIFT-1:
		cmf_pkg::WORD_SHIFT];
	// filter objects answer the host only
	assign flt_sel = host_go && host_addr_in >= cmf_pkg::FLT_BASE
		&& host_addr_in <= cmf_pkg::FLT_LAST;
	assign flt_off = host_addr_in - cmf_pkg::FLT_BASE;
	assign flt_m = flt_off[cmf_pkg::FLT_SHIFT+4:cmf_pkg::FLT_SHIFT];
	assign flt_mask = flt_off[cmf_pkg::MASK_SEL_BIT];

	// filter value and mask objects; bit 31 always reads zero
	logic [31:0] flt_val_q  [cmf_pkg::NFLT];
	logic [31:0] flt_mask_q [cmf_pkg::NFLT];
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			for (int m = 0; m < cmf_pkg::NFLT; m++)
			begin
				flt_val_q[m] <= cmf_pkg::FLT_RESET;
				flt_mask_q[m] <= cmf_pkg::FLT_RESET;
			end
		else if (flt_sel && host_we_in && !filter_enable_in[flt_m])
		begin
			if (flt_mask)
				flt_mask_q[flt_m] <= host_wdata_in & cmf_pkg::FLT_WMASK;
			else
				flt_val_q[flt_m] <= host_wdata_in & cmf_pkg::FLT_WMASK;
		end
	end

	// 39-bit words
	// no reset: ram contents survive a controller reset
	logic [38:0] mem_q [cmf_pkg::RAM_WORDS];
	logic [38:0] wcode, rd_code_q;
	logic [31:0] dec_data;
	logic        dec_single, dec_double;
	always_ff @(posedge clk_in)
	begin
		if (acc_go && acc_we && acc_ram)
			mem_q[ram_idx] <= wcode;
	end

	cmf_ecc u_ecc
	(
		.enable_in  (ecc_enable_in),
		.parity_in  (ecc_parity_in),
		.wdata_in   (acc_wdata),
		.wcode_out  (wcode),
		.rcode_in   (rd_code_q),
		.rdata_out  (dec_data),
		.single_out (dec_single),
		.double_out (dec_double)
	);

	// read stage 1: fetch raw word or filter object
	logic        rd_v_q, rd_eng_q, rd_ram_q;
	logic [31:0] rd_reg_q;
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rd_v_q <= 1'b0;
			rd_eng_q <= 1'b0;
			rd_ram_q <= 1'b0;
			rd_code_q <= '0;
			rd_reg_q <= '0;
		end
		else
		begin
			rd_v_q <= acc_go & ~acc_we;
			rd_eng_q <= eng_go;
			rd_ram_q <= acc_ram;
			rd_code_q <= mem_q[ram_idx];
			// unmapped addresses read as zero
			rd_reg_q <= !flt_sel ? 32'h00000000
				: flt_mask ? flt_mask_q[flt_m] : flt_val_q[flt_m];
		end
	end

	// read stage 2: decode and hand back
	// error flags
	logic [31:0] rdata_q;
	logic        host_rv_q, eng_rv_q;
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rdata_q <= '0;
			host_rv_q <= 1'b0;
			eng_rv_q <= 1'b0;
			ecc_single_out <= 1'b0;
			ecc_double_out <= 1'b0;
		end
		else
		begin
			rdata_q <= rd_ram_q ? dec_data : rd_reg_q;
			host_rv_q <= rd_v_q & ~rd_eng_q;
			eng_rv_q <= rd_v_q & rd_eng_q;
			ecc_single_out <= rd_v_q & rd_ram_q & dec_single;
			ecc_double_out <= rd_v_q & rd_ram_q & dec_double;
		end
	end
	assign host_rdata_out = rdata_q;
	assign eng_rdata_out = rdata_q;
	assign host_rvalid_out = host_rv_q;
	assign eng_rvalid_out = eng_rv_q;

	// acceptance: lowest enabled filter that matches wins
	logic [29:0] rx_id;
	logic        hit_any;
	logic [4:0]  hit_idx;
	assign rx_id = {rx_sid11_in, rx_eid_in, rx_sid_in};
	always_comb
	begin
		hit_any = 1'b0;
		hit_idx = '0;
		for (int m = cmf_pkg::NFLT - 1; m >= 0; m--)
			if (filter_enable_in[m]
				&& filter_fifo_ptr_in[m*5 +: 5] != cmf_pkg::FIFO_RSVD
				&& (!flt_mask_q[m][cmf_pkg::ID_TYPE_BIT]
				|| flt_val_q[m][cmf_pkg::ID_TYPE_BIT] == rx_flags_in[4])
				&& ((rx_id ^ flt_val_q[m][cmf_pkg::ID_W-1:0])
				& flt_mask_q[m][cmf_pkg::ID_W-1:0]) == '0)
			begin
				hit_any = 1'b1;
				hit_idx = 5'(m);
			end
	end

	// receive header words, held with the match result
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			match_valid_out <= 1'b0;
			matched_filter_index_out <= '0;
			match_fifo_out <= '0;
			rx_word0_out <= '0;
			rx_word1_out <= '0;
		end
		else if (rx_check_in)
		begin
			match_valid_out <= hit_any;
			matched_filter_index_out <= hit_idx;
			match_fifo_out <= filter_fifo_ptr_in[hit_idx*5 +: 5];
			rx_word0_out <= cmf_pkg::id_word(rx_sid11_in, rx_eid_in,
				rx_sid_in);
			rx_word1_out <= {16'h0000, hit_idx, 2'h0, rx_flags_in};
		end
		else
			match_valid_out <= 1'b0;
	end

	// transmit esi and event words
	logic esi_send;
	assign esi_send = esi_gateway_mode_in
		? (tx_word1_in[8] | err_passive_in) : err_passive_in;
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_esi_out <= 1'b0;
			tef_word0_out <= '0;
			tef_word1_out <= '0;
		end
		else
		begin
			tx_esi_out <= esi_send;
			tef_word0_out <= {2'h0, tx_word0_in[cmf_pkg::ID_W-1:0]};
			tef_word1_out <= {tx_word1_in[31:9], esi_send,
				tx_word1_in[cmf_pkg::FLAG_W-1:0]};
		end
	end

	// checks
	property p_cfg_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
		!config_mode_in |=> $stable(cfg_txq_q) && $stable(cfg_store_transmit_events_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("layout changed outside configuration mode");

	property p_flt_lock;
		@(posedge clk_in) disable iff (sys_rst_in)
		flt_sel && host_we_in && filter_enable_in[flt_m]
			|=> flt_val_q[$past(flt_m)] == $past(flt_val_q[flt_m])
			&& flt_mask_q[$past(flt_m)] == $past(flt_mask_q[flt_m]);
	endproperty
	a_flt_lock: assert property (p_flt_lock)
		else $error("enabled filter object was rewritten");

	property p_tef_first;
		@(posedge clk_in) disable iff (sys_rst_in)
		!cfg_store_transmit_events_q |-> base_w[0] == 12'h000;
	endproperty
	a_tef_first: assert property (p_tef_first)
		else $error("event space reserved while store is off");

	property p_txq_next;
		@(posedge clk_in) disable iff (sys_rst_in)
		!cfg_txq_q |-> base_w[1] == base_w[0];
	endproperty
	a_txq_next: assert property (p_txq_next)
		else $error("queue space reserved while queue is off");

	property p_fifo_order;
		@(posedge clk_in) disable iff (sys_rst_in)
		base_w[2] == base_w[1]
			+ 12'(objw[1] * ({1'b0, cfg_depth_q[1]} + 6'h01));
	endproperty
	a_fifo_order: assert property (p_fifo_order)
		else $error("fifo 2 does not follow fifo 1");

	property p_raw_read;
		@(posedge clk_in) disable iff (sys_rst_in)
		host_go && !host_we_in && !ecc_enable_in ##1 !ecc_enable_in
			|=> host_rvalid_out && !ecc_single_out && !ecc_double_out;
	endproperty
	a_raw_read: assert property (p_raw_read)
		else $error("raw read flagged or late");

	property p_hit_word;
		@(posedge clk_in) disable iff (sys_rst_in)
		match_valid_out |-> rx_word1_out[15:11]
			== matched_filter_index_out && match_fifo_out != 5'h00;
	endproperty
	a_hit_word: assert property (p_hit_word)
		else $error("receive word lacks filter index");

	property p_ptr0;
		@(posedge clk_in) disable iff (sys_rst_in)
		rx_check_in && filter_enable_in[0]
			&& filter_fifo_ptr_in[4:0] == cmf_pkg::FIFO_RSVD
			|=> !match_valid_out || matched_filter_index_out != 5'h00;
	endproperty
	a_ptr0: assert property (p_ptr0)
		else $error("filter aimed at fifo 0 accepted");

	property p_esi_or;
		@(posedge clk_in) disable iff (sys_rst_in)
		esi_gateway_mode_in && tx_word1_in[8] |=> tx_esi_out
			&& tef_word1_out[8];
	endproperty
	a_esi_or: assert property (p_esi_or)
		else $error("gateway esi not sent");
endmodule

// File: bench/cmf_eng_model.sv
// engine stand-in: steals ram cycles from the host port at random
// assumes word 0x400 is written before busy_in rises
`timescale 1ns/1ps
module cmf_eng_model
(
	input  wire logic        clk_in,      // system clock
	input  wire logic        sys_rst_in,  // sync reset
	input  wire logic        busy_in,     // steal cycles
	input  wire logic [31:0] rnd_in,      // random bits
	output logic             eng_req_out, // ram read request
	output logic      [11:0] eng_addr_out // read address
);
	// reads only a written word; idle address toggles, never holds
	always_ff @(posedge clk_in)
	begin
		eng_req_out <= !sys_rst_in && busy_in && rnd_in[0];
		eng_addr_out <= (sys_rst_in || (busy_in && rnd_in[0])) ?
			12'h400 : ~eng_addr_out;
	end
endmodule

// File: bench/testbench.sv
// self-checking bench: ram and ecc, filters, esi, object layout
// assumes the engine stand-in and the design package are compiled
`timescale 1ns/1ps
module testbench;
	logic        clk_in = 0, sys_rst_in = 1, config_mode_in = 1, busy = 0;
	logic        store_transmit_events_in = 1, transmit_queue_enable_in = 1;
	logic        event_timestamp_enable_in = 1, ecc_enable_in = 1;
	logic        esi_gateway_mode_in = 0, err_passive_in = 0, rx_sid11_in = 0;
	logic        host_req_in = 0, host_we_in = 0, rx_check_in = 0;
	logic        eng_req_in, host_ready_out, host_rvalid_out, eng_rvalid_out;
	logic        ecc_single_out, ecc_double_out, match_valid_out, tx_esi_out;
	logic [2:0]  txq_payload_size_in = 1;
	logic [4:0]  tef_depth_in = 1, txq_depth_in = 0, ua_sel_in = 0;
	logic [4:0]  matched_filter_index_out, match_fifo_out;
	logic [6:0]  ecc_parity_in = 0;
	logic [8:0]  rx_flags_in = 0;
	logic [10:0] rx_sid_in = 0;
	logic [11:0] host_addr_in = 0, eng_addr_in, fifo_user_address_out;
	logic [17:0] rx_eid_in = 0;
	logic [31:0] host_wdata_in = 0, tx_word0_in = 0, tx_word1_in = 0, st = 72;
	logic [31:0] filter_enable_in = 0, fifo_advance_in = 0, d[8];
	logic [31:0] host_rdata_out, eng_rdata_out, rx_word0_out, rx_word1_out;
	logic [31:0] tef_word0_out, tef_word1_out;
	logic [159:0] fifo_depth_in = 160'h20, filter_fifo_ptr_in = 160'h28000;
	logic [63:0] q_r[$], q_m[$];
	int          n_mismatch = 0, num_checks = 0;

	cmf_msg_store dut
	(
		.clk_in, .sys_rst_in, .config_mode_in, .store_transmit_events_in,
		.transmit_queue_enable_in, .event_timestamp_enable_in, .ecc_enable_in,
		.ecc_parity_in, .esi_gateway_mode_in, .err_passive_in, .tef_depth_in,
		.txq_depth_in, .txq_payload_size_in, .fifo_depth_in,
		.fifo_payload_size_in(96'h10), .receive_timestamp_enable_in(32'h6),
		.fifo_is_tx_in(32'h4), .fifo_advance_in, .ua_sel_in,
		.fifo_user_address_out, .host_req_in, .host_we_in, .host_addr_in,
		.host_wdata_in, .host_ready_out, .host_rvalid_out, .host_rdata_out,
		.eng_req_in, .eng_we_in(1'b0), .eng_addr_in, .eng_wdata_in(32'h0),
		.eng_rvalid_out, .eng_rdata_out, .ecc_single_out, .ecc_double_out,
		.filter_enable_in, .filter_fifo_ptr_in, .rx_check_in, .rx_sid11_in,
		.rx_eid_in, .rx_sid_in, .rx_flags_in, .match_valid_out,
		.matched_filter_index_out, .match_fifo_out, .rx_word0_out,
		.rx_word1_out, .tx_word0_in, .tx_word1_in, .tx_esi_out,
		.tef_word0_out, .tef_word1_out
	);

	cmf_eng_model eng
	(
		.clk_in, .sys_rst_in, .busy_in(busy), .rnd_in(st),
		.eng_req_out(eng_req_in), .eng_addr_out(eng_addr_in)
	);

	// clock and xorshift source, stepped every cycle
	always #12.5 clk_in = ~clk_in;
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	always @(posedge clk_in)
		st <= xs(st);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// empty queue yields a value no answer can carry
	function automatic logic [63:0] pop(ref logic [63:0] q[$]);
		return q.size() ? q.pop_front() : '1;
	endfunction

	// answers are matched to the oldest note as they appear
	always @(posedge clk_in)
	begin
		if (host_rvalid_out)
			chk({ecc_double_out, ecc_single_out, host_rdata_out},
				pop(q_r));
		// the engine only ever reads word 0x400, written as zero
		if (eng_rvalid_out)
			chk({ecc_double_out, ecc_single_out, eng_rdata_out},
				64'h0);
		if (match_valid_out)
			chk({matched_filter_index_out, match_fifo_out, 2'h0,
				rx_word0_out[29:0], rx_word1_out[15:0]},
				pop(q_m));
	end

	// request held until taken; caller lowers it with idle
	task automatic hop(input logic we, input logic [11:0] a,
		input logic [31:0] dt, input logic [33:0] e);
		int n;
		n = 0;
		host_req_in <= 1'b1;
		host_we_in <= we;
		host_addr_in <= a;
		host_wdata_in <= dt;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (!host_ready_out && n < 40);
		if (!we)
			q_r.push_back({30'h0, e});
	endtask

	task automatic idle();
		host_req_in <= 1'b0;
		rx_check_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask

	// back to back frames; filter 3 hits into fifo 5 when expected
	task automatic rx(input logic [10:0] s, input logic ide, input logic hit);
		logic [17:0] e;
		e = st[17:0];
		rx_check_in <= 1'b1;
		rx_sid_in <= s;
		rx_eid_in <= e;
		rx_flags_in <= {4'h0, ide, 4'h8};
		if (hit)
			q_m.push_back({5'h03, 5'h05, 3'h0, e, s, 5'h03, 6'h0, ide, 4'h8});
		@(posedge clk_in);
	endtask

	task automatic ua(input logic [4:0] sel, input logic [11:0] e);
		ua_sel_in <= sel;
		repeat (3) @(posedge clk_in);
		chk(fifo_user_address_out, e);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		#125000;
		n_mismatch++;
		test_done();
	end

	initial
	begin
		logic [31:0] w0, w1;
		logic        e;
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		// ram words with ecc on while the engine steals cycles
		hop(1'b1, 12'h400, 32'h0, 34'h0);
		busy <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			d[i] = st;
			hop(1'b1, 12'h404 + 12'(4 * i), d[i], 34'h0);
		end
		for (int i = 0; i < 8; i++)
			hop(1'b0, 12'h404 + 12'(4 * i), 32'h0, {2'h0, d[i]});
		busy <= 1'b0;
		hop(1'b0, 12'hc00, 32'h0, 34'h0);
		idle();
		// zero data with flipped check bits: one, then two errors
		ecc_enable_in <= 1'b0;
		ecc_parity_in <= 7'h01;
		hop(1'b1, 12'h444, 32'h0, 34'h0);
		ecc_parity_in <= 7'h03;
		hop(1'b1, 12'h448, 32'h0, 34'h0);
		hop(1'b1, 12'h44c, d[0], 34'h0);
		hop(1'b0, 12'h44c, 32'h0, {2'h0, d[0]});
		idle();
		ecc_enable_in <= 1'b1;
		hop(1'b0, 12'h444, 32'h0, {2'h1, 32'h0});
		hop(1'b0, 12'h448, 32'h0, {2'h2, 32'h0});
		idle();
		$display("ram and ecc done");
		// filter 3: standard ids only, all standard id bits compared
		hop(1'b0, 12'h200, 32'h0, 34'h0);
		hop(1'b1, 12'h208, 32'h800002a5, 34'h0);
		hop(1'b1, 12'h20c, 32'h400007ff, 34'h0);
		hop(1'b0, 12'h208, 32'h0, 34'h2a5);
		idle();
		// rewrite refused once enabled
		// filter 0 matches everything but points at fifo 0
		filter_enable_in <= 32'hd;
		hop(1'b1, 12'h208, 32'h0, 34'h0);
		hop(1'b1, 12'h1f0, 32'h7fffffff, 34'h0);
		hop(1'b0, 12'h208, 32'h0, 34'h2a5);
		hop(1'b0, 12'h1f0, 32'h0, 34'h0);
		idle();
		rx(11'h2a5, 1'b0, 1'b1);
		rx(11'h2a5, 1'b1, 1'b0);
		rx(11'h2a4, 1'b0, 1'b0);
		rx(11'h2a5, 1'b0, 1'b1);
		idle();
		$display("filters done");
		for (int i = 0; i < 8; i++)
		begin
			w0 = st;
			w1 = {st[31:9], i[0], st[7:0]};
			e = i[1] | (i[2] & i[0]);
			esi_gateway_mode_in <= i[2];
			err_passive_in <= i[1];
			tx_word0_in <= w0;
			tx_word1_in <= w1;
			repeat (2) @(posedge clk_in);
			chk(tx_esi_out, e);
			chk(tef_word1_out, {w1[31:9], e, w1[7:0]});
			chk(tef_word0_out[29:0], w0[29:0]);
		end
		$display("esi done");
		ua(5'h00, 12'h418);
		ua(5'h01, 12'h42c);
		ua(5'h02, 12'h464);
		ua(5'h03, 12'h474);
		config_mode_in <= 1'b0;
		@(posedge clk_in);
		for (int i = 0; i < 2; i++)
		begin
			fifo_advance_in <= 32'h2;
			@(posedge clk_in);
			fifo_advance_in <= 32'h0;
			ua(5'h01, i ? 12'h42c : 12'h448);
		end
		// layout moves only in configuration mode
		config_mode_in <= 1'b1;
		store_transmit_events_in <= 1'b0;
		ua(5'h00, 12'h400);
		ua(5'h01, 12'h414);
		transmit_queue_enable_in <= 1'b0;
		ua(5'h01, 12'h400);
		config_mode_in <= 1'b0;
		@(posedge clk_in);
		transmit_queue_enable_in <= 1'b1;
		ua(5'h01, 12'h400);
		$display("layout done");
		chk(q_r.size() + q_m.size(), 0);
		test_done();
	end
endmodule
